// ===== logic/sdbae_top.sv
`timescale 1ns/1ps
module sdbae_top
    import sdbae_pkg::*;
(
    // clock and reset
    input  wire logic                   MCLK,
    input  wire logic                   SYS_RST,
    // wishbone slave
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [3:0]             WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    // command pins
    input  wire sdbae_pkg::sdbae_cmd_s  CMD,
    // data pins
    input  wire logic [15:0]            DQ_IN,
    output logic      [15:0]            DQ_OUT,
    output logic      [1:0]             DQ_OE_N
);
    import sdbae_pkg::*;

    localparam int CL2_D = 2;
    localparam int CL3_D = 3;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0]        mem_hi [0:(1<<MEM_AW)-1];
    logic [7:0]        mem_lo [0:(1<<MEM_AW)-1];

    logic [7:0]        cfg_r;
    logic              ack_r;
    logic [31:0]       dat_r;
    sdbae_dp_e         dp_r;
    sdbae_dp_e         dp_nxt;
    logic              bank_r;
    logic              ap_r;
    logic [ROW_W-1:0]  row_r [NBANK];
    logic [1:0]        wap_sr_r;
    logic              wap_bank_r;
    logic              pipe_v_r;
    logic [15:0]       pipe_d_r;
    logic [1:0]        mask_d1_r;
    logic [15:0]       dq_r;
    logic [1:0]        oe_n_r;

    // ****************************************************************
    // command decode
    // ****************************************************************
    wire               sel       = !CMD.cs_n;
    wire               act_go    = sel && !CMD.ras_n && CMD.cas_n && CMD.we_n;
    wire               rd_go     = sel && CMD.ras_n && !CMD.cas_n && CMD.we_n;
    wire               wr_go     = sel && CMD.ras_n && !CMD.cas_n && !CMD.we_n;
    wire               pre_go    = sel && !CMD.ras_n && CMD.cas_n && !CMD.we_n;
    wire               bst_go    = sel && CMD.ras_n && CMD.cas_n && !CMD.we_n;
    wire               cmd_bank  = CMD.addr[BANK_BIT];
    wire               cmd_all   = CMD.addr[ALL_BIT];
    wire [2:0]         cfg_bl    = cfg_r[CFG_BL_LSB +: 3];
    wire [2:0]         cfg_cl    = cfg_r[CFG_CL_LSB +: 3];
    wire               cl3       = (cfg_cl == CL_3);
    wire               full_page = (cfg_bl == BL_FULL);
    wire               ap_req    = CMD.addr[ALL_BIT] && !full_page;
    wire [1:0]         pre_hit   = {2{pre_go}} & {cmd_all || cmd_bank,
                                                  cmd_all || !cmd_bank};
    wire               pre_mine  = pre_hit[bank_r];
    wire               reading   = (dp_r == DP_READ);
    wire               writing   = (dp_r == DP_WRITE);

    // ****************************************************************
    // bank state
    // ****************************************************************
    logic [COL_W-1:0]  ctr_col;
    logic              ctr_last;
    logic [1:0]        bank_open;
    logic [1:0]        bank_busy;
    logic [1:0]        pre_start;

    wire               rd_stop   = bst_go || pre_mine || wr_go;
    wire               rap_start = reading && ctr_last && ap_r && !rd_stop && !rd_go;
    wire               bl1       = (cfg_bl == BL_1);

    genvar gb;
    generate
        for (gb = 0; gb < NBANK; gb++) begin : g_bank
            assign pre_start[gb] = pre_hit[gb]
                                 || (rap_start && bank_r == 1'(gb))
                                 || (wap_sr_r[1] && wap_bank_r == 1'(gb));
            sdbae_bank_timer u_timer (
                .clk       (MCLK),
                .rst       (SYS_RST),
                .activate  (act_go && cmd_bank == 1'(gb)),
                .precharge (pre_start[gb]),
                .open_o    (bank_open[gb]),
                .busy_o    (bank_busy[gb])
            );
            always_ff @(posedge MCLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    row_r[gb] <= 11'h000;
                end else if (act_go && cmd_bank == 1'(gb) && !bank_busy[gb]) begin
                    row_r[gb] <= CMD.addr[ROW_W-1:0];
                end
            end
        end
    endgenerate

    sdbae_burst_ctr u_ctr (
        .clk        (MCLK),
        .rst        (SYS_RST),
        .load       (rd_go || wr_go),
        .adv        ((!dp_r[0] && !rd_go) || wr_go),
        .start_col  (CMD.addr[COL_W-1:0]),
        .bl         (cfg_bl),
        .interleave (cfg_r[CFG_ILV_BIT]),
        .col        (ctr_col),
        .last       (ctr_last)
    );

    // ****************************************************************
    // burst sequencing
    // ****************************************************************
    always_comb begin
        dp_nxt = dp_r;
        if (rd_go) begin
            dp_nxt = DP_READ;
        end else if (wr_go) begin
            dp_nxt = bl1 ? DP_IDLE : DP_WRITE;
        end else begin
            unique case (dp_r)
                DP_IDLE: begin
                    dp_nxt = DP_IDLE;
                end
                DP_READ: begin
                    if (rd_stop || ctr_last) begin
                        dp_nxt = DP_IDLE;
                    end
                end
                DP_WRITE: begin
                    if (bst_go || pre_mine || ctr_last) begin
                        dp_nxt = DP_IDLE;
                    end
                end
                default: dp_nxt = DP_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // write path
    // ****************************************************************
    wire               wr_cont   = writing && !bst_go && !pre_mine && !rd_go;
    wire               wr_now    = wr_go || wr_cont;
    wire               wr_bank   = wr_go ? cmd_bank : bank_r;
    wire [COL_W-1:0]   wr_col    = wr_go ? CMD.addr[COL_W-1:0] : ctr_col;
    wire [MEM_AW-1:0]  wr_addr   = {wr_bank, row_r[wr_bank], wr_col};
    wire               we_hi     = wr_now && !CMD.byte_mask_pins[1];
    wire               we_lo     = wr_now && !CMD.byte_mask_pins[0];
    wire               wr_last   = wr_go ? bl1 : (wr_cont && ctr_last);
    wire               wap_now   = wr_go ? ap_req : ap_r;

    always_ff @(posedge MCLK) begin
        if (we_hi) begin
            mem_hi[wr_addr] <= DQ_IN[15:8];
        end
        if (we_lo) begin
            mem_lo[wr_addr] <= DQ_IN[7:0];
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    wire [MEM_AW-1:0]  rd_addr   = {bank_r, row_r[bank_r], ctr_col};
    wire [15:0]        rd_word   = {mem_hi[rd_addr], mem_lo[rd_addr]};
    wire               out_v     = cl3 ? pipe_v_r : reading;
    wire [15:0]        out_d     = cl3 ? pipe_d_r : rd_word;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dp_r       <= DP_IDLE;
            bank_r     <= 1'b0;
            ap_r       <= 1'b0;
            wap_sr_r   <= 2'b00;
            wap_bank_r <= 1'b0;
        end else begin
            dp_r     <= dp_nxt;
            wap_sr_r <= {wap_sr_r[0], wr_last && wap_now};
            if (wr_last && wap_now) begin
                wap_bank_r <= wr_bank;
            end
            if (rd_go || wr_go) begin
                bank_r <= cmd_bank;
                ap_r   <= ap_req;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pipe_v_r  <= 1'b0;
            pipe_d_r  <= 16'h0000;
            mask_d1_r <= 2'b00;
            dq_r      <= 16'h0000;
            oe_n_r    <= 2'b11;
        end else begin
            pipe_v_r  <= reading;
            pipe_d_r  <= rd_word;
            mask_d1_r <= CMD.byte_mask_pins;
            dq_r      <= out_d;
            oe_n_r    <= ~({2{out_v}} & ~mask_d1_r);
        end
    end

    assign DQ_OUT  = dq_r;
    assign DQ_OE_N = oe_n_r;

    // ****************************************************************
    // wishbone registers
    // ****************************************************************
    wire               wb_req    = WB_CYC_I && WB_STB_I;
    wire               cfg_hit   = (WB_ADR_I == REG_CFG_OFS);
    wire               stat_hit  = (WB_ADR_I == REG_STAT_OFS);
    wire [31:0]        stat_word = {26'h000_0000, writing, reading, bank_busy, bank_open};
    wire [31:0]        rd_mux    = cfg_hit  ? {24'h00_0000, cfg_r}
                                 : stat_hit ? stat_word : 32'h0000_0000;
    wire               cfg_wr    = wb_req && WB_WE_I && ack_r && cfg_hit && WB_SEL_I[0];

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            cfg_r <= CFG_RST;
        end else begin
            ack_r <= wb_req && !ack_r;
            if (wb_req && !ack_r) begin
                dat_r <= rd_mux;
            end
            if (cfg_wr) begin
                cfg_r <= WB_DAT_I[7:0];
            end
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_rd_stop3;
        (rd_stop && reading && cl3) ##1 (!rd_go) [*3];
    endsequence

    sequence s_rd_stop2;
        (rd_stop && reading && !cl3) ##1 (!rd_go) [*2];
    endsequence

    property p_lowz_cl2;
        @(posedge MCLK) disable iff (SYS_RST)
        (rd_go && !cl3 && CMD.byte_mask_pins == 2'b00) |=> ##(CL2_D - 1) (DQ_OE_N == 2'b00);
    endproperty
    a_lowz_cl2: assert property (p_lowz_cl2) else $error("no output at latency two");

    property p_lowz_cl3;
        @(posedge MCLK) disable iff (SYS_RST)
        (rd_go && cl3) ##1 (CMD.byte_mask_pins == 2'b00) |=> ##(CL3_D - 2) (DQ_OE_N == 2'b00);
    endproperty
    a_lowz_cl3: assert property (p_lowz_cl3) else $error("no output at latency three");

    property p_mask_rd;
        @(posedge MCLK) disable iff (SYS_RST)
        CMD.byte_mask_pins[1] |-> ##2 DQ_OE_N[1];
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("upper byte not masked");

    property p_stop_cl3;
        @(posedge MCLK) disable iff (SYS_RST)
        s_rd_stop3 |-> (DQ_OE_N == 2'b11);
    endproperty
    a_stop_cl3: assert property (p_stop_cl3) else $error("output kept past stop");

    property p_stop_cl2;
        @(posedge MCLK) disable iff (SYS_RST)
        s_rd_stop2 |-> (DQ_OE_N == 2'b11);
    endproperty
    a_stop_cl2: assert property (p_stop_cl2) else $error("output kept past stop");

    property p_pre_all;
        @(posedge MCLK) disable iff (SYS_RST)
        (pre_go && cmd_all) |=> (bank_open == 2'b00);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("all-bank precharge missed");

    property p_pre_other;
        @(posedge MCLK) disable iff (SYS_RST)
        (writing && pre_go && !cmd_all && cmd_bank != bank_r && !rd_go && !wr_go
         && !bst_go && !ctr_last) |=> writing;
    endproperty
    a_pre_other: assert property (p_pre_other) else $error("write stopped by other bank");

    property p_wap;
        @(posedge MCLK) disable iff (SYS_RST)
        (wr_last && wap_now) |-> ##2 pre_start[$past(wr_bank, 2)];
    endproperty
    a_wap: assert property (p_wap) else $error("write auto-precharge late");

    property p_full_no_ap;
        @(posedge MCLK) disable iff (SYS_RST)
        ((rd_go || wr_go) && full_page) |=> !ap_r;
    endproperty
    a_full_no_ap: assert property (p_full_no_ap) else $error("full page auto-precharge");

    property p_bank_sel;
        @(posedge MCLK) disable iff (SYS_RST)
        rd_go |=> (bank_r == $past(CMD.addr[BANK_BIT]));
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("wrong bank taken");

endmodule : sdbae_top

// ===== shared/sdbae_pkg.sv
package sdbae_pkg;

    // ****************************************************************
    // widths and address fields
    // ****************************************************************
    localparam int ADDR_W   = 12;
    localparam int DQ_W     = 16;
    localparam int COL_W    = 8;
    localparam int ROW_W    = 11;
    localparam int MEM_AW   = 1 + ROW_W + COL_W;
    localparam int ALL_BIT  = 10;
    localparam int BANK_BIT = 11;
    localparam int NBANK    = 2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int PRECHARGE_NS  = 15;
    localparam int TRP_CYC       = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_RECOV_CYC  = 2;

    // ****************************************************************
    // burst length and latency codes
    // ****************************************************************
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_3    = 3'h3;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0]  REG_CFG_OFS  = 4'h0;
    localparam logic [3:0]  REG_STAT_OFS = 4'h4;
    localparam int          CFG_BL_LSB   = 0;
    localparam int          CFG_ILV_BIT  = 3;
    localparam int          CFG_CL_LSB   = 4;
    localparam logic [7:0]  CFG_RST      = 8'h33;
    localparam logic [15:0] WB_SEL_LOW   = 16'h0001;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        byte_mask_pins;
    } sdbae_cmd_s;

    typedef enum logic [2:0] {
        DP_IDLE  = 3'b001,
        DP_READ  = 3'b010,
        DP_WRITE = 3'b100
    } sdbae_dp_e;

    function automatic logic [COL_W-1:0] sdbae_bl_mask(input logic [2:0] bl);
        case (bl)
            BL_2:    sdbae_bl_mask = 8'h01;
            BL_4:    sdbae_bl_mask = 8'h03;
            BL_8:    sdbae_bl_mask = 8'h07;
            BL_FULL: sdbae_bl_mask = 8'hFF;
            default: sdbae_bl_mask = 8'h00;
        endcase
    endfunction : sdbae_bl_mask

endpackage : sdbae_pkg

// ===== logic/sdbae_burst_ctr.sv
`timescale 1ns/1ps
module sdbae_burst_ctr
    import sdbae_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             load,
    input  wire logic             adv,
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [2:0]       bl,
    input  wire logic             interleave,
    // burst address
    output logic      [COL_W-1:0] col,
    output logic                  last
);
    logic [COL_W-1:0] cnt_r;
    logic [COL_W-1:0] start_r;
    logic [COL_W-1:0] wrap_mask;
    logic [COL_W-1:0] seq_sum;
    logic             full_page;

    assign wrap_mask = sdbae_bl_mask(bl);
    assign full_page = (bl == BL_FULL);
    assign seq_sum   = COL_W'(start_r + cnt_r);
    assign col       = interleave && !full_page ? (start_r ^ cnt_r)
                     : ((start_r & ~wrap_mask) | (seq_sum & wrap_mask));
    assign last      = !full_page && (cnt_r == wrap_mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r   <= 8'h00;
            start_r <= 8'h00;
        end else if (load) begin
            // load with adv starts one word on: a write stores word zero on its command edge
            cnt_r   <= adv ? (8'h01 & wrap_mask) : 8'h00;
            start_r <= start_col;
        end else if (adv) begin
            cnt_r   <= COL_W'((cnt_r + 8'h01) & wrap_mask);
        end
    end

    property p_full_wrap;
        @(posedge clk) disable iff (rst)
        (adv && !load && full_page && cnt_r == 8'hFF) |=> (cnt_r == 8'h00);
    endproperty
    a_full_wrap: assert property (p_full_wrap) else $error("full page did not wrap");

endmodule : sdbae_burst_ctr

// ===== logic/sdbae_bank_timer.sv
`timescale 1ns/1ps
module sdbae_bank_timer
    import sdbae_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // events
    input  wire logic activate,
    input  wire logic precharge,
    // state
    output logic      open_o,
    output logic      busy_o
);
    localparam int TRP_D = TRP_CYC;

    logic [3:0] cnt_r;
    logic       open_r;

    // activate is accepted on the edge where the count has reached one
    assign busy_o = (cnt_r > 4'h1);
    assign open_o = open_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 4'h0;
            open_r <= 1'b0;
        end else if (precharge) begin
            cnt_r  <= 4'(TRP_CYC);
            open_r <= 1'b0;
        end else begin
            if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            if (activate && !busy_o) begin
                open_r <= 1'b1;
            end
        end
    end

    property p_idle_after_trp;
        @(posedge clk) disable iff (rst)
        (precharge ##1 !precharge [*2]) |-> ##(TRP_D - 2) !busy_o && !open_o;
    endproperty
    a_idle_after_trp: assert property (p_idle_after_trp) else $error("bank not idle");

endmodule : sdbae_bank_timer

// ===== test/sdbae_ctrl_model.sv
`timescale 1ns/1ps
module sdbae_ctrl_model
    import sdbae_pkg::*;
(
    // clock
    input  wire logic             clk,
    // command and write data toward the device
    output sdbae_pkg::sdbae_cmd_s cmd,
    output logic [15:0]           dq
);
    logic        drv_r;
    logic [15:0] dat_r;
    logic [15:0] junk_r;

    // released lines change every cycle so stale data never matches
    assign dq = drv_r ? dat_r : junk_r;

    initial begin
        cmd    = '1;
        drv_r  = 1'b0;
        dat_r  = 16'h0000;
        junk_r = 16'h5a5a;
    end

    always @(posedge clk) begin
        junk_r <= ~junk_r;
    end

    // one command per edge; op is cs_n, ras_n, cas_n, we_n
    task automatic issue(input logic [3:0] op, input logic [11:0] a, input logic [1:0] m,
                         input logic wr, input logic [15:0] d);
        @(posedge clk);
        cmd   <= {op, a, m};
        drv_r <= wr;
        dat_r <= d;
    endtask : issue
endmodule : sdbae_ctrl_model

// ===== test/tb_sdbae_top.sv
`timescale 1ns/1ps
module tb_sdbae_top;
    import sdbae_pkg::*;
    localparam logic [3:0] OP_ACT = 4'h3, OP_RD = 4'h5, OP_WR = 4'h4;
    localparam logic [3:0] OP_PRE = 4'h2, OP_BST = 4'h6, OP_NOP = 4'h7;
    logic        mclk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat, wb_q, q, lfsr;
    sdbae_cmd_s  cmd;
    logic [15:0] dq_in, dq_out;
    logic [1:0]  dq_oe_n;
    logic [15:0] mem [0:511];
    logic [1:0]  rm [0:19];
    int          err_count, total_checks, cyc_cnt;

    sdbae_top i_sdbae_top (.MCLK(mclk), .SYS_RST(sys_rst), .WB_CYC_I(wb_cyc),
        .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(4'h1),
        .WB_DAT_I(wb_dat), .WB_DAT_O(wb_q), .WB_ACK_O(wb_ack), .CMD(cmd),
        .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n));
    sdbae_ctrl_model i_sdbae_ctrl_model (.clk(mclk), .cmd(cmd), .dq(dq_in));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
        return lfsr;
    endfunction : rnd

    function automatic logic [7:0] bcol(input logic [7:0] c, input int n, input int i);
        logic [7:0] m;
        m = 8'(n - 1);
        return (c & ~m) | (8'(c + i) & m);
    endfunction : bcol

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge mclk); while (wb_ack !== 1'b1);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic bk, input logic [7:0] c, input int bl, input int n,
                      input logic [3:0] stop);
        logic [15:0] d;
        logic [1:0]  m;
        logic [8:0]  ix;
        for (int i = 0; i < n; i++) begin
            d  = 16'(rnd());
            m  = 2'(rnd()) & 2'(rnd());
            ix = {bk, bcol(c, bl, i)};
            if (!m[1]) mem[ix][15:8] = d[15:8];
            if (!m[0]) mem[ix][7:0] = d[7:0];
            i_sdbae_ctrl_model.issue(i == 0 ? OP_WR : OP_NOP, {bk, 3'h0, c}, m, 1'b1, d);
        end
        i_sdbae_ctrl_model.issue(stop, {bk, 11'h000}, 2'b00, 1'b0, 16'h0000);
    endtask : wr

    task automatic rd(input logic bk, input logic [7:0] c, input int bl, input int n,
                      input int cl, input logic [3:0] stop, input logic [11:0] sa);
        logic [15:0] ex, km;
        logic [1:0]  eo;
        for (int j = 0; j <= n + cl; j++) begin
            rm[j] = (j > 0) ? 2'(rnd()) & 2'(rnd()) : 2'b00;
            i_sdbae_ctrl_model.issue(j == 0 ? OP_RD : (j == n ? stop : OP_NOP),
                                     j == 0 ? {bk, 3'h0, c} : sa, rm[j], 1'b0, 16'h0000);
            #1;
            eo = 2'b11;
            ex = 16'h0000;
            if (j >= cl && j < cl + n) begin
                eo = rm[j - 2];
                ex = mem[{bk, bcol(c, bl, j - cl)}];
            end
            km = {{8{~eo[1]}}, {8{~eo[0]}}};
            check(32'(dq_oe_n), 32'(eo));
            check(32'(dq_out & km), 32'(ex & km));
        end
    endtask : rd

    // ****************************************************************
    // stimulus
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 8000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        logic        bk;
        logic [7:0]  c;
        logic [2:0]  blc;
        logic [11:0] pa;
        logic [1:0]  opn;
        int          bl, n;
        {sys_rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = {1'b1, 39'h0};
        {lfsr, err_count, total_checks, cyc_cnt} = {32'hf69e, 96'h0};
        opn = 2'b00;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        wb(1'b0, REG_CFG_OFS, 32'h0000_0000);
        check(q, 32'(CFG_RST));
        wb(1'b0, 4'h8, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check(32'(dq_oe_n), 32'h0000_0003);
        for (int cl = 2; cl <= 3; cl++) begin
            for (int b = 0; b <= 4; b++) begin
                bl  = (b == 4) ? 256 : (1 << b);
                blc = (b == 4) ? BL_FULL : 3'(b);
                bk  = 1'(rnd());
                c   = (b == 4) ? 8'hFA : 8'(rnd());
                pa  = {bk, 1'(rnd()), 10'h000};
                n   = (b == 4) ? 10 : 1 + int'(rnd() % bl);
                wb(1'b1, REG_CFG_OFS, {25'h0, 3'(cl), 1'b0, blc});
                i_sdbae_ctrl_model.issue(OP_ACT, {bk, 11'h000}, 2'b00, 1'b0, 16'h0000);
                i_sdbae_ctrl_model.issue(OP_NOP, 12'h000, 2'b00, 1'b0, 16'h0000);
                opn[bk] = 1'b1;
                wb(1'b0, REG_STAT_OFS, 32'h0000_0000);
                check(q, 32'(opn));
                wr(bk, c, bl, (b == 4) ? 10 : bl, (b == 4) ? OP_BST : OP_NOP);
                rd(bk, c, bl, n, cl, (b == 4) ? OP_BST : OP_PRE, pa);
                for (int k = 0; k < 5; k++) begin
                    i_sdbae_ctrl_model.issue((k == 0 && b == 4) ? OP_PRE : OP_NOP, pa,
                                             2'b00, 1'b0, 16'h0000);
                end
                if (pa[ALL_BIT]) opn = 2'b00;
                else opn[bk] = 1'b0;
            end
        end
        finish_test();
    end
endmodule : tb_sdbae_top
